// ==== pkg/lit_pkg.sv ====
// Package: constants for the legacy interval timer block
package lit_pkg;
	localparam logic [7:0] LIT_PORT_CNT0 = 8'h40;
	localparam logic [7:0] LIT_PORT_CNT1 = 8'h41;
	localparam logic [7:0] LIT_PORT_CNT2 = 8'h42;
	localparam logic [7:0] LIT_PORT_CTRL = 8'h43;
	localparam logic [7:0] LIT_PORT_SPKR = 8'h61;
	// Control word fields
	localparam int LIT_CW_SEL_HI = 7;
	localparam int LIT_CW_SEL_LO = 6;
	localparam int LIT_CW_RW_HI = 5;
	localparam int LIT_CW_RW_LO = 4;
	localparam int LIT_CW_MODE_HI = 3;
	localparam int LIT_CW_MODE_LO = 1;
	localparam int LIT_CW_BCD = 0;
	// Read-back command fields
	localparam int LIT_RB_NCOUNT = 5;
	localparam int LIT_RB_NSTAT = 4;
	localparam logic [1:0] LIT_SEL_READBACK = 2'h3;
	localparam logic [1:0] LIT_RW_LATCH = 2'h0;
	localparam logic [1:0] LIT_RW_LSB = 2'h1;
	localparam logic [1:0] LIT_RW_MSB = 2'h2;
	localparam logic [1:0] LIT_RW_BOTH = 2'h3;
	// Port 61h bits
	localparam int LIT_SPK_GATE = 0;
	localparam int LIT_SPK_EN = 1;
	localparam int LIT_SPK_OUT2 = 5;
	localparam int LIT_SPK_OUT1 = 4;
	localparam logic [7:0] LIT_SPK_RESET = 8'h00;
	// System clock 40 MHz, counter tick 1.193 MHz (838 ns)
	localparam real LIT_SYS_MHZ = 40.0;
	localparam real LIT_TICK_NS = 838.0;
	localparam int LIT_TICK_CYC = int'(LIT_TICK_NS * LIT_SYS_MHZ / 1000.0);
	localparam logic [5:0] LIT_TICK_LAST = 6'(LIT_TICK_CYC - 1);
	localparam logic [2:0] LIT_MODE_RESET = 3'h0;
	localparam logic [15:0] LIT_COUNT_RESET = 16'h0000;
	typedef enum logic [1:0] {LIT_RD_LSB, LIT_RD_MSB} lit_rdph_t;
endpackage

// ==== rtl/lit_counter.sv ====
// One 16-bit programmable down counter with six modes
`timescale 1ns/1ps
module lit_counter
	import lit_pkg::*;
(
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_tick,
	input wire logic i_gate,
	input wire logic i_prog,
	input wire logic [2:0] i_mode,
	input wire logic i_bcd,
	input wire logic i_load,
	input wire logic [15:0] i_count,
	output logic [15:0] o_count,
	output logic o_out,
	output logic o_null
);
	logic [15:0] init_q;
	logic armed_q;
	logic run_q;
	logic gate_q;
	logic [15:0] dec_v;
	logic [15:0] dec2_v;
	logic expire;
	logic one_shot;
	logic trig;
	logic start;

	// Decrement in binary or four-digit BCD
	function automatic logic [15:0] dec1(input logic [15:0] v, input logic bcd);
		logic [15:0] r;
		r = v - 16'h0001;
		if (bcd) begin
			r = v;
			for (int i = 0; i < 4; i++) begin
				if (r[i*4 +: 4] != 4'h0) begin
					r[i*4 +: 4] = r[i*4 +: 4] - 4'h1;
					break;
				end
				r[i*4 +: 4] = 4'h9;
			end
		end
		return r;
	endfunction

	assign dec_v = dec1(o_count, i_bcd);
	assign dec2_v = dec1(dec1({o_count[15:1], 1'b0}, i_bcd), i_bcd);
	assign expire = (i_mode[1:0] == 2'h2) ? (o_count == 16'h0002) : (o_count == 16'h0001);
	assign one_shot = (i_mode == 3'h1) || (i_mode == 3'h5);
	assign trig = one_shot && i_gate && !gate_q;
	// Modes 1 and 5 restart on every gate rise once a count has been taken
	assign start = (armed_q && !one_shot) || ((armed_q || run_q) && trig);

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			// Reset high so a gate already high is not seen as a trigger
			gate_q <= 1'b1;
		end else if (i_tick) begin
			gate_q <= i_gate;
		end
	end

	// Count lands on the tick after the write, in modes 1 and 5 on the tick after a gate rise, as the hardware does
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			init_q <= LIT_COUNT_RESET;
			armed_q <= 1'b0;
			o_null <= 1'b0;
		end else if (i_load) begin
			init_q <= i_count;
			armed_q <= 1'b1;
			o_null <= 1'b1;
		end else if (i_prog) begin
			armed_q <= 1'b0;
			o_null <= 1'b1;
		end else if (i_tick && start) begin
			armed_q <= 1'b0;
			o_null <= 1'b0;
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_count <= LIT_COUNT_RESET;
			run_q <= 1'b0;
			o_out <= 1'b0;
		end else if (i_prog) begin
			run_q <= 1'b0;
			o_out <= (i_mode[1:0] == 2'h0 && !i_mode[2]) || (i_mode == 3'h1) ? 1'b0 : 1'b1;
		end else if (i_tick) begin
			if (start) begin
				o_count <= (i_mode[1:0] == 2'h3) ? {init_q[15:1], 1'b0} : init_q;
				run_q <= 1'b1;
				if (i_mode[1:0] == 2'h3) begin
					o_out <= 1'b1;
				end
				if (i_mode == 3'h0) begin
					o_out <= 1'b0;
				end
				if (i_mode == 3'h1) begin
					o_out <= 1'b0;
				end
			end else if (run_q && (i_gate || i_mode == 3'h1 || i_mode == 3'h5)) begin
				case (i_mode[1:0])
					2'h3: begin
						if (o_count == 16'h0002 || o_count == 16'h0000 && init_q == 16'h0000) begin
							o_out <= !o_out;
							o_count <= {init_q[15:1], 1'b0};
						end else begin
							o_count <= dec2_v;
						end
					end
					2'h2: begin
						if (expire) begin
							o_out <= 1'b0;
							o_count <= dec_v;
						end else if (o_count == 16'h0001) begin
							o_out <= 1'b1;
							o_count <= init_q;
						end else begin
							o_out <= 1'b1;
							o_count <= dec_v;
						end
					end
					default: begin
						o_count <= dec_v;
						if (i_mode == 3'h0) begin
							if (expire) begin
								o_out <= 1'b1;
							end
						end else if (i_mode == 3'h1) begin
							o_out <= expire;
						end else begin
							o_out <= !expire;
						end
					end
				endcase
			end
		end
	end
endmodule

// ==== rtl/lit_timer.sv ====
// Three-counter interval timer with control port and speaker control port
`timescale 1ns/1ps
module lit_timer
	import lit_pkg::*;
(
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_io_wr,
	input wire logic i_io_rd,
	input wire logic [7:0] i_io_addr,
	input wire logic [7:0] i_io_wdata,
	output logic [7:0] o_io_rdata,
	output logic o_system_timer_irq,
	output logic o_refresh_req,
	output logic o_speaker
);
	logic [5:0] div_q;
	logic tick_q;
	logic [7:0] spk_q;
	logic [1:0] rw_q [3];
	logic [2:0] mode_q [3];
	logic bcd_q [3];
	logic wr_msb_q [3];
	logic [7:0] lsb_q [3];
	logic rd_msb_q [3];
	logic cl_q [3];
	logic sl_q [3];
	logic [15:0] latch_q [3];
	logic [7:0] stat_q [3];
	logic prog [3];
	logic load [3];
	logic [15:0] load_val [3];
	logic [15:0] cnt [3];
	logic outs [3];
	logic nulls [3];
	logic ctrl_wr;
	logic [1:0] sel;
	logic cnt_sel;
	logic [1:0] ca;
	logic [7:0] rd_v;

	// Codes 6 and 7 are aliases of the rate and square wave modes
	function automatic logic [2:0] cw_mode(input logic [7:0] w);
		return w[2] ? {1'b0, w[2:1]} : w[LIT_CW_MODE_HI:LIT_CW_MODE_LO];
	endfunction

	// Integer tick close to 1.193 MHz; exact 14.31818/12 needs a fractional divider
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			div_q <= 6'h00;
			tick_q <= 1'b0;
		end else begin
			tick_q <= (div_q == LIT_TICK_LAST);
			div_q <= (div_q == LIT_TICK_LAST) ? 6'h00 : div_q + 6'h01;
		end
	end

	assign ctrl_wr = i_io_wr && i_io_addr == LIT_PORT_CTRL;
	assign sel = i_io_wdata[LIT_CW_SEL_HI:LIT_CW_SEL_LO];
	assign cnt_sel = i_io_addr[7:2] == LIT_PORT_CNT0[7:2] && i_io_addr[1:0] != 2'h3;
	assign ca = i_io_addr[1:0];

	for (genvar c = 0; c < 3; c++) begin : g_cnt
		logic is_wr;
		logic is_rd;
		logic cw_hit;
		logic rb_hit;
		assign is_wr = i_io_wr && cnt_sel && ca == 2'(c);
		assign is_rd = i_io_rd && cnt_sel && ca == 2'(c);
		assign cw_hit = ctrl_wr && sel == 2'(c);
		assign rb_hit = ctrl_wr && sel == LIT_SEL_READBACK && i_io_wdata[c + 1];
		assign prog[c] = cw_hit && i_io_wdata[LIT_CW_RW_HI:LIT_CW_RW_LO] != LIT_RW_LATCH;
		// Load fires when the last byte of the format arrives
		assign load[c] = is_wr && (rw_q[c] != LIT_RW_BOTH || wr_msb_q[c]);
		always_comb begin
			case (rw_q[c])
				LIT_RW_LSB: load_val[c] = {8'h00, i_io_wdata};
				LIT_RW_MSB: load_val[c] = {i_io_wdata, 8'h00};
				default: load_val[c] = {i_io_wdata, lsb_q[c]};
			endcase
		end

		// Control word updates mode; a count write leaves it alone
		always_ff @(posedge i_clock or negedge i_rst_n) begin
			if (!i_rst_n) begin
				rw_q[c] <= LIT_RW_LSB;
				mode_q[c] <= LIT_MODE_RESET;
				bcd_q[c] <= 1'b0;
			end else if (prog[c]) begin
				rw_q[c] <= i_io_wdata[LIT_CW_RW_HI:LIT_CW_RW_LO];
				mode_q[c] <= cw_mode(i_io_wdata);
				bcd_q[c] <= i_io_wdata[LIT_CW_BCD];
			end
		end

		always_ff @(posedge i_clock or negedge i_rst_n) begin
			if (!i_rst_n) begin
				wr_msb_q[c] <= 1'b0;
				lsb_q[c] <= 8'h00;
			end else if (prog[c]) begin
				wr_msb_q[c] <= 1'b0;
			end else if (is_wr && rw_q[c] == LIT_RW_BOTH) begin
				wr_msb_q[c] <= !wr_msb_q[c];
				if (!wr_msb_q[c]) begin
					lsb_q[c] <= i_io_wdata;
				end
			end
		end

		// Count latch: first latch wins until fully read
		always_ff @(posedge i_clock or negedge i_rst_n) begin
			if (!i_rst_n) begin
				cl_q[c] <= 1'b0;
				latch_q[c] <= LIT_COUNT_RESET;
			end else if (prog[c]) begin
				cl_q[c] <= 1'b0;
			end else if (((cw_hit && i_io_wdata[LIT_CW_RW_HI:LIT_CW_RW_LO] == LIT_RW_LATCH)
				|| (rb_hit && !i_io_wdata[LIT_RB_NCOUNT])) && !cl_q[c]) begin
				cl_q[c] <= 1'b1;
				latch_q[c] <= cnt[c];
			end else if (is_rd && !sl_q[c] && (rw_q[c] != LIT_RW_BOTH || rd_msb_q[c])) begin
				cl_q[c] <= 1'b0;
			end
		end

		always_ff @(posedge i_clock or negedge i_rst_n) begin
			if (!i_rst_n) begin
				sl_q[c] <= 1'b0;
				stat_q[c] <= 8'h00;
			end else if (prog[c]) begin
				sl_q[c] <= 1'b0;
			end else if (rb_hit && !i_io_wdata[LIT_RB_NSTAT] && !sl_q[c]) begin
				sl_q[c] <= 1'b1;
				stat_q[c] <= {outs[c], nulls[c], rw_q[c], mode_q[c], bcd_q[c]};
			end else if (is_rd) begin
				sl_q[c] <= 1'b0;
			end
		end

		always_ff @(posedge i_clock or negedge i_rst_n) begin
			if (!i_rst_n) begin
				rd_msb_q[c] <= 1'b0;
			end else if (prog[c]) begin
				rd_msb_q[c] <= 1'b0;
			end else if (is_rd && !sl_q[c] && rw_q[c] == LIT_RW_BOTH) begin
				rd_msb_q[c] <= !rd_msb_q[c];
			end
		end

		lit_counter u_cnt (
			.i_clock(i_clock),
			.i_rst_n(i_rst_n),
			.i_tick(tick_q),
			.i_gate(c == 2 ? spk_q[LIT_SPK_GATE] : 1'b1),
			.i_prog(prog[c]),
			.i_mode(prog[c] ? cw_mode(i_io_wdata) : mode_q[c]),
			.i_bcd(bcd_q[c]),
			.i_load(load[c]),
			.i_count(load_val[c]),
			.o_count(cnt[c]),
			.o_out(outs[c]),
			.o_null(nulls[c])
		);
	end

	// Read mux: status, then latched count, then live count
	always_comb begin
		logic [15:0] v;
		v = 16'h0000;
		rd_v = 8'h00;
		if (cnt_sel) begin
			v = cl_q[ca] ? latch_q[ca] : cnt[ca];
			if (sl_q[ca]) begin
				rd_v = stat_q[ca];
			end else if (rw_q[ca] == LIT_RW_MSB || (rw_q[ca] == LIT_RW_BOTH && rd_msb_q[ca])) begin
				rd_v = v[15:8];
			end else begin
				rd_v = v[7:0];
			end
		end else if (i_io_addr == LIT_PORT_SPKR) begin
			rd_v = {2'b00, outs[2], outs[1], 2'b00, spk_q[1:0]};
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_io_rdata <= 8'h00;
		end else if (i_io_rd) begin
			o_io_rdata <= rd_v;
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			spk_q <= LIT_SPK_RESET;
		end else if (i_io_wr && i_io_addr == LIT_PORT_SPKR) begin
			spk_q <= i_io_wdata;
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_system_timer_irq <= 1'b0;
			o_refresh_req <= 1'b0;
			o_speaker <= 1'b0;
		end else begin
			o_system_timer_irq <= outs[0];
			o_refresh_req <= outs[1];
			o_speaker <= outs[2] && spk_q[LIT_SPK_EN];
		end
	end
endmodule

// ==== bench/lit_timer_asserts.sv ====
// Checker: port-level assertions for the interval timer
`timescale 1ns/1ps
module lit_timer_asserts
	import lit_pkg::*;
(
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_io_wr,
	input wire logic i_io_rd,
	input wire logic [7:0] i_io_addr,
	input wire logic [7:0] i_io_wdata,
	input wire logic [7:0] o_io_rdata,
	input wire logic o_system_timer_irq,
	input wire logic o_refresh_req,
	input wire logic o_speaker
);
	logic [1:0] p61_q;
	logic [7:0] low_q;
	logic seen_q;
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);
	// Shadow of the speaker control bits, kept from writes alone
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			p61_q <= 2'h0;
		end else if (i_io_wr && i_io_addr == LIT_PORT_SPKR) begin
			p61_q <= i_io_wdata[1:0];
		end
	end
	// First rise is skipped: the low time before programming is arbitrary
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			low_q <= 8'h00;
			seen_q <= 1'b0;
		end else begin
			low_q <= o_refresh_req ? 8'h00 : low_q + 8'h01;
			seen_q <= seen_q | o_refresh_req;
		end
	end
	sequence s_rb_stat0;
		i_io_wr && i_io_addr == LIT_PORT_CTRL && i_io_wdata == 8'hE2;
	endsequence
	sequence s_rd_cnt0;
		i_io_rd && i_io_addr == LIT_PORT_CNT0;
	endsequence
	AST_RST_OUT: assert property ($rose(i_rst_n) |-> o_io_rdata == 8'h00 && !o_speaker
		&& !o_system_timer_irq && !o_refresh_req) else $error("outputs not clear after reset");
	AST_UNMAPPED_RD: assert property (i_io_rd && !(i_io_addr inside {8'h40, 8'h41, 8'h42, 8'h43, 8'h61})
		|=> o_io_rdata == 8'h00) else $error("unmapped read not zero");
	AST_RDATA_HOLD: assert property (!i_io_rd |=> $stable(o_io_rdata)) else $error("read data moved");
	AST_SPK_EN: assert property (!p61_q[1] && !$past(p61_q[1]) && !$past(p61_q[1], 2) |-> !o_speaker)
		else $error("speaker active while disabled");
	AST_P61_RD: assert property (i_io_rd && !i_io_wr && i_io_addr == LIT_PORT_SPKR
		|=> o_io_rdata[1:0] == p61_q) else $error("speaker control read wrong");
	AST_IRQ_PHASE: assert property ($changed(o_system_timer_irq) |=> $stable(o_system_timer_irq)[*8])
		else $error("timer irq phase too short");
	AST_REFRESH_PULSE: assert property ($rose(o_refresh_req) && seen_q |-> low_q == 8'(LIT_TICK_CYC))
		else $error("refresh low time not one tick");
	AST_STATUS0: assert property (s_rb_stat0 ##2 s_rd_cnt0 |=> o_io_rdata[5:0] == 6'h36)
		else $error("counter 0 status wrong");
endmodule

bind lit_timer lit_timer_asserts u_chk (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_io_wr(i_io_wr),
	.i_io_rd(i_io_rd), .i_io_addr(i_io_addr), .i_io_wdata(i_io_wdata), .o_io_rdata(o_io_rdata),
	.o_system_timer_irq(o_system_timer_irq), .o_refresh_req(o_refresh_req), .o_speaker(o_speaker));

// ==== bench/tb_top.sv ====
// Testbench: self-checking run for the interval timer
`timescale 1ns/1ps
module tb_top;
	import lit_pkg::*;
	localparam int TK = LIT_TICK_CYC;
	logic i_clock, i_rst_n, i_io_wr, i_io_rd;
	logic [7:0] i_io_addr, i_io_wdata, o_io_rdata;
	logic o_system_timer_irq, o_refresh_req, o_speaker;
	int err_total = 0;
	int comparisons = 0;
	int seed = 32'h811c;
	int n, i, m;
	logic [7:0] b, lo, hi;
	logic [15:0] cnt;
	lit_timer i_dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_io_wr(i_io_wr), .i_io_rd(i_io_rd),
		.i_io_addr(i_io_addr), .i_io_wdata(i_io_wdata), .o_io_rdata(o_io_rdata),
		.o_system_timer_irq(o_system_timer_irq), .o_refresh_req(o_refresh_req), .o_speaker(o_speaker));
	initial begin
		i_clock = 1'b0;
		forever #12.5 i_clock = ~i_clock;
	end
	task automatic summarize;
		$display("checks %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clock);
		i_io_wr <= 1'b1;
		i_io_addr <= a;
		i_io_wdata <= d;
		@(posedge i_clock);
		i_io_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge i_clock);
		i_io_rd <= 1'b1;
		i_io_addr <= a;
		@(posedge i_clock);
		i_io_rd <= 1'b0;
		#1 d = o_io_rdata;
	endtask
	function automatic logic sig(input int k);
		return k == 0 ? o_system_timer_irq : (k == 1 ? o_refresh_req : o_speaker);
	endfunction
	function automatic int half(input int c);
		return c / 2 * TK;
	endfunction
	function automatic logic [15:0] loaded(input int f, input logic [15:0] c);
		return f == 1 ? {8'h00, c[7:0]} : (f == 2 ? {c[15:8], 8'h00} : c);
	endfunction
	// Waits for three level changes; the first one aligns, the two later ones are full phases
	task automatic phase(input int k, input int hi_n, input int lo_n);
		logic v;
		int c;
		for (int p = 0; p < 3; p++) begin
			v = sig(k);
			c = 0;
			while (sig(k) === v && c < 9000) begin
				@(negedge i_clock);
				c++;
			end
			if (p > 0) chk(16'(c), 16'(v ? hi_n : lo_n));
		end
	endtask
	// Timer irq edges mark ticks, so a load can be placed clear of the next tick
	task automatic sync;
		phase(0, half(6), half(6));
	endtask
	task automatic rd2(input logic [7:0] a, input int f);
		lo = 8'h00;
		hi = 8'h00;
		if (f != 2) rd(a, lo);
		if (f != 1) rd(a, hi);
	endtask
	initial begin
		repeat (40000) @(posedge i_clock);
		err_total++;
		summarize;
	end
	initial begin
		i_rst_n = 1'b0;
		i_io_wr = 1'b0;
		i_io_rd = 1'b0;
		i_io_addr = 8'h00;
		i_io_wdata = 8'h00;
		repeat (4) @(posedge i_clock);
		i_rst_n <= 1'b1;
		@(negedge i_clock);
		chk({o_system_timer_irq, o_refresh_req, o_speaker}, 16'h0);
		rd(8'h50, b);
		chk(b, 8'h00);
		$display("test 1 done");
		wr(LIT_PORT_CTRL, 8'h36);
		wr(LIT_PORT_CNT0, 8'h06);
		wr(LIT_PORT_CNT0, 8'h00);
		phase(0, half(6), half(6));
		wr(LIT_PORT_CTRL, 8'hE2);
		rd(LIT_PORT_CNT0, b);
		chk(b[5:0], 6'h36);
		wr(LIT_PORT_CTRL, 8'h74);
		wr(LIT_PORT_CNT1, 8'h04);
		wr(LIT_PORT_CNT1, 8'h00);
		phase(1, 3 * TK, TK);
		$display("test 2 done");
		n = 4 + ($random(seed) & 12);
		wr(LIT_PORT_SPKR, 8'h03);
		wr(LIT_PORT_CTRL, 8'hB6);
		wr(LIT_PORT_CNT2, 8'(n));
		wr(LIT_PORT_CNT2, 8'h00);
		phase(2, half(n), half(n));
		rd(LIT_PORT_SPKR, b);
		chk(b[1:0], 2'h3);
		wr(LIT_PORT_SPKR, 8'h01);
		@(posedge i_clock);
		for (i = 0; i < 200; i++) begin
			@(negedge i_clock);
			chk(o_speaker, 1'b0);
		end
		$display("test 3 done");
		wr(LIT_PORT_SPKR, 8'h00);
		for (i = 1; i < 4; i++) begin
			cnt = 16'($random(seed)) | 16'h0100;
			sync;
			wr(LIT_PORT_CTRL, {4'h8 | 4'(i), 4'h0});
			if (i != 2) wr(LIT_PORT_CNT2, cnt[7:0]);
			if (i != 1) wr(LIT_PORT_CNT2, cnt[15:8]);
			wr(LIT_PORT_CTRL, 8'hE8);
			rd(LIT_PORT_CNT2, b);
			chk(b[6], 1'b1);
			repeat (2 * TK) @(posedge i_clock);
			wr(LIT_PORT_CTRL, 8'hE8);
			rd(LIT_PORT_CNT2, b);
			chk(b, {4'h0 | 4'(i), 4'h0});
			wr(LIT_PORT_CTRL, 8'h80);
			rd2(LIT_PORT_CNT2, i);
			chk({hi, lo}, loaded(i, cnt));
		end
		wr(LIT_PORT_CTRL, 8'hC8);
		rd(LIT_PORT_CNT2, b);
		chk(b[5:0], 6'h30);
		rd2(LIT_PORT_CNT2, 3);
		chk({hi, lo}, cnt);
		wr(LIT_PORT_CTRL, 8'h80);
		wr(LIT_PORT_SPKR, 8'h01);
		repeat (5 * TK) @(posedge i_clock);
		wr(LIT_PORT_CTRL, 8'h80);
		wr(LIT_PORT_SPKR, 8'h00);
		rd2(LIT_PORT_CNT2, 3);
		chk({hi, lo}, cnt);
		wr(LIT_PORT_CTRL, 8'h80);
		rd2(LIT_PORT_CNT2, 3);
		chk(16'({hi, lo} < cnt), 16'h1);
		$display("test 4 done");
		wr(LIT_PORT_SPKR, 8'h03);
		wr(LIT_PORT_CTRL, 8'hB0);
		wr(LIT_PORT_CNT2, 8'h03);
		wr(LIT_PORT_CNT2, 8'h00);
		@(negedge i_clock);
		chk(o_speaker, 1'b0);
		repeat (6 * TK) @(negedge i_clock);
		chk(o_speaker, 1'b1);
		repeat (10 * TK) @(negedge i_clock);
		chk(o_speaker, 1'b1);
		wr(LIT_PORT_CNT2, 8'h03);
		wr(LIT_PORT_CNT2, 8'h00);
		wr(LIT_PORT_CTRL, 8'hE8);
		rd(LIT_PORT_CNT2, b);
		chk(b[5:0], 6'h30);
		wr(LIT_PORT_SPKR, 8'h00);
		wr(LIT_PORT_CTRL, 8'hB1);
		wr(LIT_PORT_CNT2, 8'h00);
		wr(LIT_PORT_CNT2, 8'h01);
		repeat (2 * TK) @(posedge i_clock);
		wr(LIT_PORT_SPKR, 8'h01);
		repeat (5 * TK) @(posedge i_clock);
		wr(LIT_PORT_SPKR, 8'h00);
		wr(LIT_PORT_CTRL, 8'h80);
		rd2(LIT_PORT_CNT2, 3);
		chk(16'({hi, lo} >= 16'h0090 && {hi, lo} <= 16'h0099), 16'h1);
		wr(LIT_PORT_SPKR, 8'h02);
		wr(LIT_PORT_CTRL, 8'hB2);
		wr(LIT_PORT_CNT2, 8'h03);
		wr(LIT_PORT_CNT2, 8'h00);
		repeat (2 * TK) @(posedge i_clock);
		wr(LIT_PORT_SPKR, 8'h03);
		i = 0;
		for (m = 0; m < 8 * TK; m++) begin
			@(negedge i_clock);
			if (o_speaker === 1'b1) i++;
		end
		chk(16'(i), 16'(TK));
		for (m = 0; m < 6; m++) begin
			wr(LIT_PORT_CTRL, {4'hB, 3'(m), 1'b0});
			wr(LIT_PORT_CTRL, 8'hE8);
			rd(LIT_PORT_CNT2, b);
			chk({b[7], b[5:0]}, {m >= 2, 2'h3, 3'(m), 1'b0});
		end
		$display("test 5 done");
		summarize;
	end
endmodule
